// *** hw/perf_sel_pkg.sv ***
// Package for the frontend and offcore event-select decode.
// Assumes one core clock domain and pipeline units that supply
// per-cycle event quantities on the same clock.
package perf_sel_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int EVT_W = 8;
    localparam int UMASK_W = 8;
    localparam int CMASK_W = 8;
    localparam int QTY_W = 8;
    localparam int OCC_W = 6;
    localparam int UOP_W = 3;
    localparam int BR_W = 3;
    localparam int TERM_N = 8;

    // ************************************************************
    // Event numbers
    // ************************************************************
    localparam logic [7:0] EVT_OFFCORE_OUT = 8'h60;
    localparam logic [7:0] EVT_LOCK_CYCLES = 8'h63;
    localparam logic [7:0] EVT_UOP_QUEUE = 8'h79;
    localparam logic [7:0] EVT_ICACHE = 8'h80;
    localparam logic [7:0] EVT_ITRANS_MISS = 8'h85;
    localparam logic [7:0] EVT_PREFIX_STALL = 8'h87;
    localparam logic [7:0] EVT_BRANCH_EXEC = 8'h88;

    // ************************************************************
    // Unit mask bit positions
    // ************************************************************
    localparam int UM_RFO_BIT = 2;
    localparam int UM_DATA_RD_BIT = 3;
    localparam int UM_LOCK_BOTH_BIT = 0;
    localparam int UM_LOCK_L1D_BIT = 1;
    localparam int UM_EMPTY_BIT = 1;
    localparam int UM_LEGACY_BIT = 2;
    localparam int UM_STREAM_BIT = 3;
    localparam int UM_SEQ_STREAM_BIT = 4;
    localparam int UM_SEQ_LEGACY_BIT = 5;
    localparam int UM_IC_MISS_BIT = 1;
    localparam int UM_WALK_START_BIT = 0;
    localparam int UM_WALK_DONE_BIT = 1;
    localparam int UM_WALK_BUSY_BIT = 4;
    localparam int UM_SHARED_HIT_BIT = 5;
    localparam int UM_PREFIX_BIT = 0;
    localparam int UM_COND_BIT = 0;
    localparam int UM_NOT_TAKEN_BIT = 6;
    localparam int UM_TAKEN_BIT = 7;

    // ************************************************************
    // Unit mask values that have a defined meaning
    // ************************************************************
    localparam logic [7:0] UM_01 = 8'h01;
    localparam logic [7:0] UM_02 = 8'h02;
    localparam logic [7:0] UM_04 = 8'h04;
    localparam logic [7:0] UM_08 = 8'h08;
    localparam logic [7:0] UM_0C = 8'h0C;
    localparam logic [7:0] UM_10 = 8'h10;
    localparam logic [7:0] UM_18 = 8'h18;
    localparam logic [7:0] UM_20 = 8'h20;
    localparam logic [7:0] UM_24 = 8'h24;
    localparam logic [7:0] UM_30 = 8'h30;
    localparam logic [7:0] UM_3C = 8'h3C;
    localparam logic [7:0] UM_41 = 8'h41;
    localparam logic [7:0] UM_81 = 8'h81;
    localparam logic [7:0] UM_C1 = 8'hC1;

    // Reset values
    localparam logic [QTY_W-1:0] QTY_ZERO = 8'h00;

    // Programmed selection fields
    typedef struct packed {
        logic enable;
        logic [EVT_W-1:0] event_num;
        logic [UMASK_W-1:0] umask;
        logic [CMASK_W-1:0] cmask;
        logic edge_det;
    } event_sel_t;

    // Per-cycle event quantities from the pipeline units
    typedef struct packed {
        logic [OCC_W-1:0] ownership_read_outstanding;
        logic [OCC_W-1:0] data_read_outstanding;
        logic lock_l1d_and_l2;
        logic lock_l1d_only;
        logic uop_queue_empty_evt;
        logic [UOP_W-1:0] legacy_path_uops_evt;
        logic [UOP_W-1:0] stream_cache_uops_evt;
        logic sequencer_busy_flag;
        logic instr_cache_miss_evt;
        logic walk_started;
        logic walk_completed_4k;
        logic page_miss_handler_busy;
        logic shared_translation_buffer_hit_4k;
        logic prefix_length_stall_evt;
        logic [BR_W-1:0] cond_branch_taken;
        logic [BR_W-1:0] cond_branch_not_taken;
    } event_src_t;

endpackage

// *** hw/threshold_edge_qualifier.sv ***
// Count-mask threshold and edge qualifier for one event counter.
// Assumes a decoded per-cycle quantity on the same clock as sys_clk.
`timescale 1ns/1ps
module threshold_edge_qualifier
    import perf_sel_pkg::*;
#(
    parameter int QW = QTY_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic active,
    input wire logic [QW-1:0] qty,
    input wire logic [CMASK_W-1:0] cmask,
    input wire logic edge_det,
    output logic [QW-1:0] incr
);

    // ************************************************************
    // Threshold compare
    // ************************************************************
    logic [15:0] qty_ext;
    logic [15:0] cmask_ext;
    logic cmask_zero;
    logic cond_now;
    logic cond_prev;
    logic rising;
    logic [QW-1:0] next_incr;

    // Widen both sides to 16 bits so width pairings up to 16 bits compare cleanly
    assign qty_ext = 16'(qty);
    assign cmask_ext = 16'(cmask);
    assign cmask_zero = (cmask == '0);
    // Condition: nonzero quantity, or at least the count mask
    assign cond_now = active & (cmask_zero ? (qty != '0) : (qty_ext >= cmask_ext));
    assign rising = cond_now & ~cond_prev;

    // Quantity, threshold pulse, or rising-edge pulse
    assign next_incr = !active ? '0 :
                       edge_det ? QW'(rising) :
                       cmask_zero ? qty : QW'(cond_now);

    // ************************************************************
    // Registers
    // ************************************************************
    // Increment and edge history
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            incr <= '0;
            cond_prev <= 1'b0;
        end else begin
            incr <= next_incr;
            cond_prev <= cond_now;
        end
    end

endmodule

// *** hw/perf_event_select_frontend_offcore.sv ***
// Event-select decode for frontend and offcore performance events.
// Assumes event sources and selection fields are on the core clock.
//
// How it works
// - 60H/04H adds outstanding ownership-read requests
// - 60H/08H adds outstanding cacheable data reads
// - 63H/01H counts cycles both caches locked
// - 63H/02H counts cycles first-level cache locked
// - 79H/02H counts cycles decoded queue empty
// - 79H/04H adds legacy path uops, combines 20H
// - 79H/08H adds stream cache uops, combines 10H
// - 79H/10H sequencer stream uops; edge counts deliveries
// - 79H/20H adds sequencer uops via legacy path
// - 79H/30H adds all sequencer uops
// - 79H/18H stream cache cycles, cmask 1 or 4
// - 79H/24H legacy path cycles, cmask 1 or 4
// - 80H/02H counts instruction cache misses
// - 85H/01H counts translation misses starting walks
// - 85H/02H counts completed 4K instruction walks
// - 85H/10H counts cycles page walker busy
// - 85H/20H counts shared translation buffer hits
// - 87H/01H counts length changing prefix stalls
// - 88H/01H conditional branches, needs 40H or 80H
`timescale 1ns/1ps
module perf_event_select_frontend_offcore
    import perf_sel_pkg::*;
#(
    parameter int QW = QTY_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire event_sel_t sel,
    input wire event_src_t src,
    input wire logic multithreading_feature,
    output logic [QW-1:0] incr,
    output logic select_supported,
    output logic select_misuse
);

    // ************************************************************
    // Event group decode
    // ************************************************************
    logic is_offcore;
    logic is_lock;
    logic is_uop_queue;
    logic is_icache;
    logic is_itrans;
    logic is_prefix;
    logic is_branch;

    // One wire per event number in this part of the table
    assign is_offcore = (sel.event_num == EVT_OFFCORE_OUT);
    assign is_lock = (sel.event_num == EVT_LOCK_CYCLES);
    assign is_uop_queue = (sel.event_num == EVT_UOP_QUEUE);
    assign is_icache = (sel.event_num == EVT_ICACHE);
    assign is_itrans = (sel.event_num == EVT_ITRANS_MISS);
    assign is_prefix = (sel.event_num == EVT_PREFIX_STALL);
    assign is_branch = (sel.event_num == EVT_BRANCH_EXEC);

    // ************************************************************
    // Source quantities widened to the counter step width
    // ************************************************************
    logic [QW-1:0] q_rfo;
    logic [QW-1:0] q_data_rd;
    logic [QW-1:0] q_legacy;
    logic [QW-1:0] q_stream;
    logic [QW-1:0] q_taken;
    logic [QW-1:0] q_not_taken;
    logic seq_busy;

    // Zero-extend every multi-bit source
    assign q_rfo = QW'(src.ownership_read_outstanding);
    assign q_data_rd = QW'(src.data_read_outstanding);
    assign q_legacy = QW'(src.legacy_path_uops_evt);
    assign q_stream = QW'(src.stream_cache_uops_evt);
    assign q_taken = QW'(src.cond_branch_taken);
    assign q_not_taken = QW'(src.cond_branch_not_taken);
    assign seq_busy = src.sequencer_busy_flag;

    // ************************************************************
    // Per-bit terms of the decoded uop queue group
    // ************************************************************
    logic [QW-1:0] uq_term [TERM_N];
    logic [QW-1:0] uq_legacy_plain;
    logic [QW-1:0] uq_stream_plain;
    logic [QW-1:0] uq_stream_seq;
    logic [QW-1:0] uq_legacy_seq;

    // Split each path by sequencer activity so masks add up exactly
    assign uq_legacy_plain = seq_busy ? '0 : q_legacy;
    assign uq_stream_plain = seq_busy ? '0 : q_stream;
    assign uq_stream_seq = seq_busy ? q_stream : '0;
    assign uq_legacy_seq = seq_busy ? q_legacy : '0;

    // Term table, one entry per unit mask bit
    always_comb begin
        for (int k = 0; k < TERM_N; k++) begin
            uq_term[k] = '0;
        end
        uq_term[UM_EMPTY_BIT] = QW'(src.uop_queue_empty_evt);
        uq_term[UM_LEGACY_BIT] = uq_legacy_plain;
        uq_term[UM_STREAM_BIT] = uq_stream_plain;
        uq_term[UM_SEQ_STREAM_BIT] = uq_stream_seq;
        uq_term[UM_SEQ_LEGACY_BIT] = uq_legacy_seq;
    end

    // ************************************************************
    // Per-bit terms of the remaining groups
    // ************************************************************
    logic [QW-1:0] oc_term [TERM_N];
    logic [QW-1:0] lk_term [TERM_N];
    logic [QW-1:0] ic_term [TERM_N];
    logic [QW-1:0] it_term [TERM_N];
    logic [QW-1:0] px_term [TERM_N];
    logic [QW-1:0] br_term [TERM_N];
    logic cond_qual;

    // Conditional qualifier gates the taken and not-taken terms
    assign cond_qual = sel.umask[UM_COND_BIT];

    // Term tables; bits with no meaning stay zero
    always_comb begin
        for (int k = 0; k < TERM_N; k++) begin
            oc_term[k] = '0;
            lk_term[k] = '0;
            ic_term[k] = '0;
            it_term[k] = '0;
            px_term[k] = '0;
            br_term[k] = '0;
        end
        oc_term[UM_RFO_BIT] = q_rfo;
        oc_term[UM_DATA_RD_BIT] = q_data_rd;
        lk_term[UM_LOCK_BOTH_BIT] = QW'(src.lock_l1d_and_l2);
        lk_term[UM_LOCK_L1D_BIT] = QW'(src.lock_l1d_only);
        ic_term[UM_IC_MISS_BIT] = QW'(src.instr_cache_miss_evt);
        it_term[UM_WALK_START_BIT] = QW'(src.walk_started);
        it_term[UM_WALK_DONE_BIT] = QW'(src.walk_completed_4k);
        it_term[UM_WALK_BUSY_BIT] = QW'(src.page_miss_handler_busy);
        it_term[UM_SHARED_HIT_BIT] = QW'(src.shared_translation_buffer_hit_4k);
        px_term[UM_PREFIX_BIT] = QW'(src.prefix_length_stall_evt);
        br_term[UM_NOT_TAKEN_BIT] = cond_qual ? q_not_taken : '0;
        br_term[UM_TAKEN_BIT] = cond_qual ? q_taken : '0;
    end

    // ************************************************************
    // Unit mask gated sum over the selected group
    // ************************************************************
    logic [QW-1:0] sel_term [TERM_N];
    logic [QW-1:0] partial [TERM_N+1];
    logic [QW-1:0] qty;

    assign partial[0] = '0;

    // Each set unit mask bit adds its term; 30H, 18H, 24H, 3CH fall out
    for (genvar i = 0; i < TERM_N; i++) begin : g_term
        assign sel_term[i] = is_offcore ? oc_term[i] :
                             is_lock ? lk_term[i] :
                             is_uop_queue ? uq_term[i] :
                             is_icache ? ic_term[i] :
                             is_itrans ? it_term[i] :
                             is_prefix ? px_term[i] :
                             is_branch ? br_term[i] : '0;
        assign partial[i+1] = partial[i] + (sel.umask[i] ? sel_term[i] : '0);
    end

    assign qty = partial[TERM_N];

    // ************************************************************
    // Supported selections
    // ************************************************************
    logic ok_offcore;
    logic ok_lock;
    logic ok_uq_single;
    logic ok_uq_combo;
    logic ok_single;
    logic ok_branch;
    logic next_supported;

    // Documented mask values and their allowed combinations
    assign ok_offcore = is_offcore & (sel.umask == UM_04 || sel.umask == UM_08);
    assign ok_lock = is_lock & (sel.umask == UM_01 || sel.umask == UM_02);
    assign ok_uq_single = is_uop_queue & (sel.umask == UM_02 || sel.umask == UM_04 ||
                          sel.umask == UM_08 || sel.umask == UM_10 || sel.umask == UM_20);
    assign ok_uq_combo = is_uop_queue & (sel.umask == UM_30 || sel.umask == UM_18 ||
                         sel.umask == UM_24 || sel.umask == UM_0C || sel.umask == UM_3C);
    assign ok_single = (is_icache & sel.umask == UM_02) |
                       (is_itrans & (sel.umask == UM_01 || sel.umask == UM_02 ||
                        sel.umask == UM_10 || sel.umask == UM_20)) |
                       (is_prefix & sel.umask == UM_01);
    assign ok_branch = is_branch & (sel.umask == UM_41 || sel.umask == UM_81 ||
                       sel.umask == UM_C1);
    assign next_supported = ok_offcore | ok_lock | ok_uq_single | ok_uq_combo |
                            ok_single | ok_branch;

    // ************************************************************
    // Software misuse indication
    // ************************************************************
    logic misuse_offcore;
    logic misuse_branch;
    logic next_misuse;

    // Offcore occupancy is not meaningful with two threads sharing it
    assign misuse_offcore = is_offcore & multithreading_feature;
    // Conditional qualifier alone never counts anything
    assign misuse_branch = is_branch & cond_qual &
                           ~(sel.umask[UM_TAKEN_BIT] | sel.umask[UM_NOT_TAKEN_BIT]);
    assign next_misuse = sel.enable & (misuse_offcore | misuse_branch);

    // ************************************************************
    // Threshold and edge stage
    // ************************************************************
    logic active;

    // Only enabled, decodable selections reach the counter
    assign active = sel.enable & next_supported;

    // Cmask 1 gives any-delivery cycles, 4 gives four-uop cycles
    threshold_edge_qualifier #(
        .QW(QW)
    ) u_qual (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .active(active),
        .qty(qty),
        .cmask(sel.cmask),
        .edge_det(sel.edge_det),
        .incr(incr)
    );

    // ************************************************************
    // Status registers
    // ************************************************************
    // Registered in step with the increment
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            select_supported <= 1'b0;
            select_misuse <= 1'b0;
        end else begin
            select_supported <= next_supported;
            select_misuse <= next_misuse;
        end
    end

endmodule

// *** sim/perf_src_model.sv ***
// Partner model: pipeline units giving per-cycle event quantities.
// Assumes one core clock; hold freezes the values to act as a slow source.
`timescale 1ns/1ps
module perf_src_model
    import perf_sel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic hold,
    output event_src_t src
);
    logic [63:0] raw;

    // ************************************************************
    // Fresh quantities shortly after each edge unless held
    // ************************************************************
    initial src = '0;
    always @(posedge sys_clk) begin
        #1;
        if (!hold) begin
            raw = {$urandom, $urandom};
            src = raw[$bits(event_src_t)-1:0];
        end
    end
endmodule

// *** sim/perf_sel_monitor.sv ***
// Checker for the frontend and offcore event-select decode.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module perf_sel_monitor
    import perf_sel_pkg::*;
#(
    parameter int QW = QTY_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire event_sel_t sel,
    input wire event_src_t src,
    input wire logic multithreading_feature,
    input wire logic [QW-1:0] incr,
    input wire logic select_supported,
    input wire logic select_misuse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // Selection decode
    // ************************************************************
    wire logic plain = sel.enable && sel.cmask == 8'h00 && !sel.edge_det;
    wire logic thr = sel.enable && !sel.edge_det;
    wire logic [15:0] pick = {sel.event_num, sel.umask};
    wire logic seq_now = src.sequencer_busy_flag && src.stream_cache_uops_evt != 3'h0;

    property p_off_disabled;
        !sel.enable |=> incr == '0 && !select_misuse;
    endproperty
    a_off_disabled: assert property (p_off_disabled) else $error("count while disabled");
    property p_rfo;
        plain && pick == 16'h6004 |=> incr == QW'($past(src.ownership_read_outstanding));
    endproperty
    a_rfo: assert property (p_rfo) else $error("ownership read occupancy wrong");
    property p_data_rd;
        plain && pick == 16'h6008 |=> incr == QW'($past(src.data_read_outstanding));
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("data read occupancy wrong");
    property p_lock_both;
        plain && pick == 16'h6301 |=> incr == QW'($past(src.lock_l1d_and_l2));
    endproperty
    a_lock_both: assert property (p_lock_both) else $error("both-lock cycle wrong");
    property p_lock_l1d;
        plain && pick == 16'h6302 |=> incr == QW'($past(src.lock_l1d_only));
    endproperty
    a_lock_l1d: assert property (p_lock_l1d) else $error("l1d lock cycle wrong");
    property p_empty;
        plain && pick == 16'h7902 |=> incr == QW'($past(src.uop_queue_empty_evt));
    endproperty
    a_empty: assert property (p_empty) else $error("queue empty cycle wrong");
    property p_stream4;
        thr && sel.cmask == 8'h04 && pick == 16'h7918
            |=> incr == QW'($past(src.stream_cache_uops_evt) >= 3'h4);
    endproperty
    a_stream4: assert property (p_stream4) else $error("four-uop cycle wrong");
    property p_legacy_any;
        thr && sel.cmask == 8'h01 && pick == 16'h7924
            |=> incr == QW'($past(src.legacy_path_uops_evt) != 3'h0);
    endproperty
    a_legacy_any: assert property (p_legacy_any) else $error("legacy cycle wrong");
    property p_seq_edge;
        sel.enable && sel.edge_det && sel.cmask == 8'h00 && pick == 16'h7910 && seq_now
            && $past(rst_n) && $past(sel) == sel && $past(seq_now) |=> incr == '0;
    endproperty
    a_seq_edge: assert property (p_seq_edge) else $error("edge counted twice");
    property p_misuse_br;
        sel.enable && pick == 16'h8801 |=> select_misuse && incr == '0;
    endproperty
    a_misuse_br: assert property (p_misuse_br) else $error("branch qualifier missing");
    property p_misuse_smt;
        sel.enable && sel.event_num == 8'h60 && multithreading_feature |=> select_misuse;
    endproperty
    a_misuse_smt: assert property (p_misuse_smt) else $error("smt use not flagged");

    // Main scenarios reached
    c_edge: cover property (sel.edge_det && pick == 16'h7910 ##1 incr == 8'h01);
    c_four: cover property (pick == 16'h7918 && sel.cmask == 8'h04 ##1 incr == 8'h01);
    c_misuse: cover property (select_misuse);
endmodule

bind perf_event_select_frontend_offcore perf_sel_monitor #(.QW(QW)) i_mon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel(sel),
    .src(src),
    .multithreading_feature(multithreading_feature),
    .incr(incr),
    .select_supported(select_supported),
    .select_misuse(select_misuse)
);

// *** sim/perf_event_select_frontend_offcore_bench.sv ***
// Self-checking bench for the frontend and offcore event-select decode.
// Assumes the partner model drives src; a reference predicts every cycle.
`timescale 1ns/1ps
module perf_event_select_frontend_offcore_bench;
    import perf_sel_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mt = 1'b0;
    logic hold = 1'b0;
    logic chk_on = 1'b0;
    logic prev = 1'b0;
    logic exp_sup = 1'b0;
    logic exp_mis = 1'b0;
    logic [7:0] exp_incr = 8'h00;
    event_sel_t sel = '0;
    event_src_t src;
    logic [7:0] incr;
    logic sup;
    logic mis;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] ev_list [7] = '{8'h60, 8'h63, 8'h79, 8'h80, 8'h85, 8'h87, 8'h88};
    logic [7:0] um_list [14] = '{UM_01, UM_02, UM_04, UM_08, UM_0C, UM_10, UM_18,
        UM_20, UM_24, UM_30, UM_3C, UM_41, UM_81, UM_C1};

    always #2 sys_clk = ~sys_clk;

    perf_event_select_frontend_offcore i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sel(sel),
        .src(src), .multithreading_feature(mt), .incr(incr), .select_supported(sup),
        .select_misuse(mis));
    perf_src_model i_src (.sys_clk(sys_clk), .hold(hold), .src(src));

    // ************************************************************
    // Reference functions
    // ************************************************************
    function automatic logic supported(event_sel_t s);
        case (s.event_num)
            8'h60: return s.umask inside {8'h04, 8'h08};
            8'h63: return s.umask inside {8'h01, 8'h02};
            8'h79: return s.umask inside {8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h30, 8'h18,
                8'h24, 8'h0C, 8'h3C};
            8'h80: return s.umask == 8'h02;
            8'h85: return s.umask inside {8'h01, 8'h02, 8'h10, 8'h20};
            8'h87: return s.umask == 8'h01;
            8'h88: return s.umask inside {8'h41, 8'h81, 8'hC1};
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] qty(event_sel_t s, event_src_t r);
        logic [7:0] u;
        logic b;
        u = s.umask;
        b = r.sequencer_busy_flag;
        case (s.event_num)
            8'h60: return u[2] * r.ownership_read_outstanding + u[3] * r.data_read_outstanding;
            8'h63: return u[0] * r.lock_l1d_and_l2 + u[1] * r.lock_l1d_only;
            8'h79: return u[1] * r.uop_queue_empty_evt + u[2] * !b * r.legacy_path_uops_evt
                + u[3] * !b * r.stream_cache_uops_evt + u[4] * b * r.stream_cache_uops_evt
                + u[5] * b * r.legacy_path_uops_evt;
            8'h80: return u[1] * r.instr_cache_miss_evt;
            8'h85: return u[0] * r.walk_started + u[1] * r.walk_completed_4k
                + u[4] * r.page_miss_handler_busy + u[5] * r.shared_translation_buffer_hit_4k;
            8'h87: return u[0] * r.prefix_length_stall_evt;
            8'h88: return u[0] * (u[6] * r.cond_branch_not_taken + u[7] * r.cond_branch_taken);
            default: return 8'h00;
        endcase
    endfunction

    // Predict outputs from inputs sampled at each edge
    always @(posedge sys_clk) begin
        logic act;
        logic c;
        logic [7:0] q;
        q = qty(sel, src);
        act = rst_n && sel.enable && supported(sel);
        c = act && (sel.cmask == 8'h00 ? q != 8'h00 : q >= sel.cmask);
        exp_sup = rst_n && supported(sel);
        exp_mis = rst_n && sel.enable && ((sel.event_num == 8'h60 && mt)
            || (sel.event_num == 8'h88 && sel.umask[0] && !sel.umask[6] && !sel.umask[7]));
        exp_incr = !act ? 8'h00 : sel.edge_det ? {7'h0, c && !prev}
            : sel.cmask == 8'h00 ? q : {7'h0, c};
        prev = c;
        chk_on = 1'b1;
    end

    // Compare settled outputs mid-cycle
    always @(negedge sys_clk) begin
        if (chk_on) begin
            check(incr, exp_incr);
            check({7'h0, sup}, {7'h0, exp_sup});
            check({7'h0, mis}, {7'h0, exp_mis});
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // Enable defaults high; the random phase also drives it low
    task automatic run(input logic [7:0] ev, um, cm, input logic ed, input int n,
        input logic en = 1'b1);
        sel = '{enable: en, event_num: ev, umask: um, cmask: cm, edge_det: ed};
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic conclude();
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #100000;
        err_count++;
        conclude();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h64f7));
        repeat (8) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        run(8'h60, 8'h04, 8'h00, 1'b0, 20);
        run(8'h60, 8'h08, 8'h00, 1'b0, 20);
        run(8'h60, 8'h08, 8'h01, 1'b0, 20);
        mt = 1'b1;
        run(8'h60, 8'h04, 8'h01, 1'b0, 10);
        mt = 1'b0;
        run(8'h63, 8'h01, 8'h00, 1'b0, 20);
        run(8'h63, 8'h02, 8'h00, 1'b0, 20);
        run(8'h79, 8'h02, 8'h00, 1'b0, 20);
        run(8'h79, 8'h04, 8'h00, 1'b0, 20);
        run(8'h79, 8'h08, 8'h00, 1'b0, 20);
        run(8'h79, 8'h10, 8'h00, 1'b1, 30);
        run(8'h79, 8'h10, 8'h01, 1'b0, 20);
        run(8'h79, 8'h20, 8'h00, 1'b0, 20);
        run(8'h79, 8'h30, 8'h00, 1'b0, 20);
        run(8'h79, 8'h18, 8'h01, 1'b0, 20);
        run(8'h79, 8'h18, 8'h04, 1'b0, 30);
        run(8'h79, 8'h24, 8'h01, 1'b0, 20);
        run(8'h79, 8'h24, 8'h04, 1'b0, 30);
        run(8'h80, 8'h02, 8'h00, 1'b0, 20);
        run(8'h85, 8'h01, 8'h00, 1'b0, 20);
        run(8'h85, 8'h02, 8'h00, 1'b0, 20);
        run(8'h85, 8'h10, 8'h00, 1'b0, 20);
        run(8'h85, 8'h20, 8'h00, 1'b0, 20);
        run(8'h87, 8'h01, 8'h00, 1'b0, 20);
        run(8'h88, 8'h41, 8'h00, 1'b0, 20);
        run(8'h88, 8'h81, 8'h00, 1'b0, 20);
        run(8'h88, 8'hC1, 8'h02, 1'b0, 20);
        run(8'h88, 8'h01, 8'h00, 1'b0, 10);
        // Reset again while counting with edge detection
        run(8'h79, 8'h3C, 8'h00, 1'b1, 5);
        rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        // Random selections, thresholds, source stalls
        repeat (1500) begin
            mt = 1'($urandom);
            hold = ($urandom_range(0, 3) == 0);
            run(ev_list[$urandom_range(0, 6)], $urandom_range(0, 1) ? um_list[$urandom_range(0, 13)]
                : 8'($urandom), 8'($urandom_range(0, 5)), 1'($urandom), 1,
                ($urandom_range(0, 7) != 0));
        end
        conclude();
    end
endmodule
